// File: hw/edpo_pkg.sv
package edpo_pkg;
   // ==========================================
   // Setting codes
   // ==========================================
   localparam logic [1:0] SRC_MOTOR        = 2'h0;
   localparam logic [1:0] SRC_EXTERNAL     = 2'h1;
   localparam logic [1:0] POL_A_NORM_Z_HI  = 2'h0;
   localparam logic [1:0] POL_A_INV_Z_HI   = 2'h1;
   localparam logic [1:0] POL_A_NORM_Z_LO  = 2'h2;
   localparam logic [1:0] POL_A_INV_Z_LO   = 2'h3;
   localparam logic [1:0] FMT_BINARY       = 2'h0;
   localparam logic [1:0] FMT_DECIMAL      = 2'h1;
   localparam logic [1:0] FMT_PASSTHRU     = 2'h2;
   localparam logic [1:0] CLR_STATUS_MULTI = 2'h0;
   localparam logic [1:0] CLR_STATUS_ONLY  = 2'h1;
   // Bit positions inside the polarity code
   localparam int POL_A_INV_BIT = 0;
   localparam int POL_Z_LOW_BIT = 1;
   // ==========================================
   // Sizes and reset values
   // ==========================================
   localparam int RATIO_W       = 16;
   localparam int POS_W         = 32;
   localparam int DIGITS        = 10;
   localparam int DIG_W         = 4;
   localparam int SER_W         = DIGITS * 8;
   localparam logic [7:0] ASCII_ZERO = 8'h30;
   localparam logic [1:0] QUAD_RST   = 2'h0;

   typedef enum logic [3:0] {
      EDPO_IDLE  = 4'h1,
      EDPO_CONV  = 4'h2,
      EDPO_LOAD  = 4'h4,
      EDPO_SHIFT = 4'h8
   } edpo_ser_e;
endpackage : edpo_pkg

// File: hw/edpo_top.sv
`timescale 1ns/1ps
module edpo_top
   import edpo_pkg::*;
#(
   parameter int RW = RATIO_W
) (
   // Clock, reset, enable
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             clk_en,
   // Configuration
   input  wire logic [1:0]       pulse_source,
   input  wire logic             fully_closed,
   input  wire logic             motor_abs_enc,
   input  wire logic [RW-1:0]    pulse_division_ratio,
   input  wire logic [1:0]       divided_output_polarity,
   input  wire logic [1:0]       position_format,
   input  wire logic [1:0]       clear_mode,
   // Encoder count events (one-cycle pulses), markers and raw lines
   input  wire logic             mot_step,
   input  wire logic             mot_dir,
   input  wire logic             mot_z,
   input  wire logic             mot_raw,
   input  wire logic             ext_step,
   input  wire logic             ext_dir,
   input  wire logic             ext_z,
   input  wire logic             ext_raw,
   // Position to report and clear request
   input  wire logic [POS_W-1:0] position,
   input  wire logic             pos_request,
   input  wire logic             clear_req,
   // Divided outputs
   output logic                  out_a,
   output logic                  out_b,
   output logic                  out_z,
   // Serial position output
   output logic                  serial_position_output,
   output logic                  ser_busy,
   // Clear commands to the encoder interface
   output logic                  clr_status,
   output logic                  clr_multiturn
);
   import edpo_pkg::*;

   // ==========================================
   // Source selection
   // ==========================================
   wire use_ext = (pulse_source == SRC_EXTERNAL) ||
                  (fully_closed && motor_abs_enc);
   wire sel_step = use_ext ? ext_step : mot_step;
   wire sel_dir  = use_ext ? ext_dir  : mot_dir;
   wire sel_z    = use_ext ? ext_z    : mot_z;
   wire sel_raw  = use_ext ? ext_raw  : mot_raw;

   // ==========================================
   // Divider and quadrature state
   // ==========================================
   logic [RW-1:0] div_cnt;
   logic [1:0]    quad;
   wire [RW-1:0] ratio_eff = (pulse_division_ratio == '0) ? RW'(1) : pulse_division_ratio;
   wire div_hit = sel_step && (div_cnt + RW'(1) >= ratio_eff);
   wire [RW-1:0] next_div_cnt = !sel_step ? div_cnt : (div_hit ? '0 : div_cnt + RW'(1));
   // Gray step: forward 00->01->11->10, reverse the other way
   wire [1:0] next_quad = sel_dir ? {quad[0], ~quad[1]} : {~quad[0], quad[1]};

   wire a_inv = divided_output_polarity[POL_A_INV_BIT];
   wire z_low = divided_output_polarity[POL_Z_LOW_BIT];

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         div_cnt <= '0;
         quad    <= QUAD_RST;
         out_a   <= 1'b0;
         out_b   <= 1'b0;
         out_z   <= 1'b0;
      end else if (clk_en) begin
         div_cnt <= next_div_cnt;
         if (div_hit) begin
            quad <= next_quad;
         end
         out_a <= (div_hit ? next_quad[1] : quad[1]) ^ a_inv;
         out_b <= div_hit ? next_quad[0] : quad[0];
         out_z <= sel_z ^ z_low;
      end
   end

   // ==========================================
   // Serial position output
   // ==========================================
   // Format is latched once after reset release, so changes wait for the next reset
   logic [1:0]       fmt;
   logic             fmt_taken;
   edpo_ser_e        st;
   logic [POS_W-1:0] bin;
   logic [DIGITS*DIG_W-1:0] bcd;
   // Wide enough to count the 80 bits of a decimal frame, not only 32
   localparam int CW = $clog2(SER_W);
   logic [CW-1:0]    bit_cnt;
   logic [SER_W-1:0] shreg;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         fmt       <= FMT_BINARY;
         fmt_taken <= 1'b0;
      end else if (clk_en && !fmt_taken) begin
         fmt       <= position_format;
         fmt_taken <= 1'b1;
      end
   end

   // Double-dabble add-3 on every digit above 4 before each shift
   logic [DIGITS*DIG_W-1:0] bcd_adj;
   always_comb begin
      bcd_adj = bcd;
      for (int d = 0; d < DIGITS; d++) begin
         if (bcd[d*DIG_W +: DIG_W] > 4'h4) begin
            bcd_adj[d*DIG_W +: DIG_W] = bcd[d*DIG_W +: DIG_W] + 4'h3;
         end
      end
   end

   logic [SER_W-1:0] ascii;
   always_comb begin
      ascii = '0;
      for (int d = 0; d < DIGITS; d++) begin
         ascii[d*8 +: 8] = ASCII_ZERO | {4'h0, bcd[d*DIG_W +: DIG_W]};
      end
   end

   wire [CW-1:0] ser_len = (fmt == FMT_DECIMAL) ? CW'(SER_W - 1) : CW'(POS_W - 1);
   wire conv_done = (bit_cnt == CW'(POS_W - 1));

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st      <= EDPO_IDLE;
         bin     <= '0;
         bcd     <= '0;
         bit_cnt <= '0;
         shreg   <= '0;
         ser_busy <= 1'b0;
         serial_position_output <= 1'b0;
      end else if (clk_en) begin
         case (st)
            EDPO_IDLE: begin
               ser_busy <= 1'b0;
               serial_position_output <= (fmt == FMT_PASSTHRU) ? sel_raw : 1'b0;
               if (pos_request && fmt != FMT_PASSTHRU) begin
                  bin      <= position;
                  bcd      <= '0;
                  bit_cnt  <= '0;
                  ser_busy <= 1'b1;
                  st       <= (fmt == FMT_DECIMAL) ? EDPO_CONV : EDPO_LOAD;
               end
            end
            EDPO_CONV: begin
               bcd     <= {bcd_adj[DIGITS*DIG_W-2:0], bin[POS_W-1]};
               bin     <= {bin[POS_W-2:0], 1'b0};
               bit_cnt <= bit_cnt + CW'(1);
               if (conv_done) begin
                  st <= EDPO_LOAD;
               end
            end
            EDPO_LOAD: begin
               // MSB first in either format
               shreg   <= (fmt == FMT_DECIMAL) ? ascii
                                               : {bin, {(SER_W-POS_W){1'b0}}};
               bit_cnt <= '0;
               st      <= EDPO_SHIFT;
            end
            EDPO_SHIFT: begin
               serial_position_output <= shreg[SER_W-1];
               shreg   <= {shreg[SER_W-2:0], 1'b0};
               bit_cnt <= bit_cnt + CW'(1);
               if (bit_cnt == ser_len) begin
                  st <= EDPO_IDLE;
               end
            end
            default: st <= EDPO_IDLE;
         endcase
      end
   end

   // ==========================================
   // Encoder clear
   // ==========================================
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         clr_status    <= 1'b0;
         clr_multiturn <= 1'b0;
      end else if (clk_en) begin
         clr_status    <= clear_req;
         clr_multiturn <= clear_req && (clear_mode == CLR_STATUS_MULTI);
      end
   end

   // ==========================================
   // Checks
   // ==========================================
   a_src_external: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && fully_closed && motor_abs_enc && ext_z |=> out_z != z_low || $changed(divided_output_polarity))
      else $error("external marker not routed");
   a_clear_only_status: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && clear_req && clear_mode == CLR_STATUS_ONLY |=> clr_status && !clr_multiturn)
      else $error("status-only clear touched multi-turn");
   a_clear_full: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && clear_req && clear_mode == CLR_STATUS_MULTI |=> clr_status && clr_multiturn)
      else $error("full clear incomplete");
   a_fmt_held: assert property (@(posedge sys_clk) disable iff (rst)
      fmt_taken |=> $stable(fmt))
      else $error("format changed without power cycle");
   a_quad_gray: assert property (@(posedge sys_clk) disable iff (rst)
      $changed(quad) |-> ^(quad ^ $past(quad)))
      else $error("quadrature moved two phases");
   a_div_bound: assert property (@(posedge sys_clk) disable iff (rst)
      div_cnt < ratio_eff || $changed(pulse_division_ratio))
      else $error("divider overran ratio");
endmodule // edpo_top

// File: testbench/edpo_host_model.sv
`timescale 1ns/1ps
module edpo_host_model (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // Divided outputs and polarity in use
   input  wire logic       out_a,
   input  wire logic       out_b,
   input  wire logic [1:0] pol,
   // Net quadrature count
   output int              count
);
   logic [1:0] prev;
   logic [1:0] cur;
   assign cur = {out_a ^ pol[0], out_b};
   // Two-state jumps are treated as glitches, as a real counter would
   always @(negedge sys_clk or posedge rst) begin
      if (rst) begin
         count <= 0;
         prev  <= 2'h0;
      end else begin
         if (cur == {prev[0], ~prev[1]}) count <= count + 1;
         else if (prev == {cur[0], ~cur[1]}) count <= count - 1;
         prev <= cur;
      end
   end
endmodule // edpo_host_model

// File: testbench/encoder_divided_pulse_output_test.sv
`timescale 1ns/1ps
module encoder_divided_pulse_output_test;
   import edpo_pkg::*;
   logic sys_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, fully_closed = 1'b0, motor_abs_enc = 1'b0;
   logic [1:0] pulse_source = 2'h0, pol = 2'h0, fmt = 2'h0, cmode = 2'h0;
   logic [15:0] ratio = 16'h1;
   logic mot_step = 0, mot_dir = 0, mot_z = 0, mot_raw = 0, ext_step = 0, ext_dir = 0;
   logic ext_z = 0, ext_raw = 0, pos_request = 0, clear_req = 0;
   logic [31:0] position = 32'h0;
   logic out_a, out_b, out_z, ser, ser_busy, clr_status, clr_multiturn;
   logic [79:0] v;
   int n_errors = 0, cmp_count = 0, count, rt;
   always #4 sys_clk = ~sys_clk;
   logic raw_q = 1'b0;
   always @(posedge sys_clk) mot_raw <= 1'($urandom);
   // Pass-through copies the selected raw line through one register
   always @(posedge sys_clk) raw_q <= mot_raw;
   edpo_top dut_u (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .pulse_source(pulse_source),
      .fully_closed(fully_closed), .motor_abs_enc(motor_abs_enc), .pulse_division_ratio(ratio),
      .divided_output_polarity(pol), .position_format(fmt), .clear_mode(cmode),
      .mot_step(mot_step), .mot_dir(mot_dir), .mot_z(mot_z), .mot_raw(mot_raw),
      .ext_step(ext_step), .ext_dir(ext_dir), .ext_z(ext_z), .ext_raw(ext_raw),
      .position(position), .pos_request(pos_request), .clear_req(clear_req), .out_a(out_a),
      .out_b(out_b), .out_z(out_z), .serial_position_output(ser), .ser_busy(ser_busy),
      .clr_status(clr_status), .clr_multiturn(clr_multiturn));
   edpo_host_model host_u (.sys_clk(sys_clk), .rst(rst), .out_a(out_a), .out_b(out_b),
      .pol(pol), .count(count));
   // ==========================================
   // Compare and closing tasks
   // ==========================================
   task automatic chk(input string what, input logic [79:0] exp, input logic [79:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_cnt(input string what, input int exp, input int got);
      cmp_count++;
      if (got != exp) begin
         n_errors++;
         $display("Error %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   task automatic test_done();
      if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ==========================================
   // Drivers
   // ==========================================
   task automatic do_reset(input logic [1:0] f);
      @(posedge sys_clk);
      rst <= 1'b1;
      fmt <= f;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask
   task automatic get_ser(input int start, input int n);
      v = '0;
      @(posedge sys_clk);
      position <= $urandom;
      pos_request <= 1'b1;
      @(posedge sys_clk);
      pos_request <= 1'b0;
      repeat (start) @(posedge sys_clk);
      for (int i = 0; i < n; i++) begin
         @(negedge sys_clk);
         v = {v[78:0], ser};
         if (i == 0) chk("ser busy", start > 0, ser_busy);
         @(posedge sys_clk);
      end
   endtask
   function automatic logic [79:0] to_ascii(input logic [31:0] x);
      longint unsigned y = x;
      for (int i = 0; i < 10; i++) begin
         to_ascii[i*8 +: 8] = ASCII_ZERO + 8'(y % 10);
         y = y / 10;
      end
   endfunction
   // Phase 2 forces external through fully-closed; phase 3 is absolute alone, so motor
   task automatic run_phase(input int p);
      int m, e, c0, sel;
      m = $urandom_range(6, 1) * rt;
      e = $urandom_range(6, 1) * rt;
      sel = (p == 1 || p == 2);
      @(posedge sys_clk);
      pulse_source <= (p == 1) ? SRC_EXTERNAL : SRC_MOTOR;
      fully_closed <= (p == 2);
      motor_abs_enc <= (p >= 2);
      pol <= 2'(p);
      mot_dir <= (p != 3);
      ext_dir <= (p != 2);
      repeat (4) @(posedge sys_clk);
      c0 = count;
      for (int i = 0; i < (m > e ? m : e); i++) begin
         mot_step <= (i < m);
         ext_step <= (i < e);
         @(posedge sys_clk);
      end
      mot_step <= 1'b0;
      ext_step <= 1'b0;
      mot_z <= !sel;
      ext_z <= sel;
      repeat (4) @(posedge sys_clk);
      chk_cnt("quad count", (sel ? e : m) / rt * ((p < 2) ? 1 : -1), count - c0);
      chk("out_z active", p < 2, out_z);
      mot_z <= 1'b0;
      ext_z <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk("out_z idle", p >= 2, out_z);
   endtask
   // ==========================================
   // Main sequence
   // ==========================================
   initial begin
      void'($urandom(32'h8d6bb9d9));
      rt = $urandom_range(4, 1);
      ratio = 16'(rt);
      do_reset(FMT_BINARY);
      for (int p = 0; p < 4; p++) run_phase(p);
      // Status-only clear is what an incremental setup would pick
      for (int c = 0; c < 2; c++) begin
         @(posedge sys_clk);
         cmode <= 2'(c);
         clear_req <= 1'b1;
         @(posedge sys_clk);
         clear_req <= 1'b0;
         @(negedge sys_clk);
         chk("clear pair", {1'b1, c == 0}, {clr_status, clr_multiturn});
         @(negedge sys_clk);
         chk("clear idle", 2'h0, {clr_status, clr_multiturn});
      end
      // A request seen only while the enable is low must leave no trace
      @(posedge sys_clk);
      clk_en <= 1'b0;
      clear_req <= 1'b1;
      repeat (2) @(posedge sys_clk);
      clear_req <= 1'b0;
      clk_en <= 1'b1;
      @(negedge sys_clk);
      chk("frozen clear", 2'h0, {clr_status, clr_multiturn});
      get_ser(2, 32);
      chk("binary", 80'(position), v);
      fmt <= FMT_DECIMAL;
      get_ser(2, 32);
      chk("format held", 80'(position), v);
      do_reset(FMT_DECIMAL);
      get_ser(34, 80);
      chk("decimal", to_ascii(position), v);
      do_reset(FMT_PASSTHRU);
      get_ser(0, 4);
      chk("passthru busy", 1'b0, ser_busy);
      repeat (4) begin
         @(negedge sys_clk);
         chk("passthru", raw_q, ser);
      end
      test_done();
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_errors++;
      test_done();
   end
endmodule // encoder_divided_pulse_output_test
